//--- pkg/aim_pkg.sv
// Purpose: Shared constants for the analog input limit monitor.
// Assumes: Parameter and record bytes are addressed by their subindex.
// Notes:   Signed constants are kept signed so that compares stay signed.
package aim_pkg;
  localparam int          NCH        = 4;
  localparam int          VAL_W      = 16;
  // ==========================================================
  // Parameter subindices
  localparam logic [7:0]  SX_DGI_EN  = 8'h01;
  localparam logic [7:0]  SX_LIM_EN  = 8'h03;
  localparam logic [7:0]  SX_SUPP    = 8'h04;
  localparam logic [7:0]  SX_CH_BASE = 8'h05;
  localparam logic [7:0]  SX_CH_SPAN = 8'h10;
  localparam logic [1:0]  SLOT_FN    = 2'h0;
  localparam logic [1:0]  SLOT_UL    = 2'h2;
  localparam logic [1:0]  SLOT_LL    = 2'h3;
  // ==========================================================
  // Hardware-interrupt record subindices
  localparam logic [7:0]  SX_REC_OVF = 8'h02;
  localparam logic [7:0]  SX_REC_UDF = 8'h03;
  localparam logic [7:0]  SX_REC_TSH = 8'h04;
  localparam logic [7:0]  SX_REC_TSL = 8'h05;
  // ==========================================================
  // Codes and reset values
  localparam logic [7:0]  DIAG_OFF   = 8'h00;
  localparam logic [7:0]  DIAG_ON    = 8'h40;
  localparam logic [7:0]  FN_FMT10   = 8'h10;
  localparam logic [7:0]  FN_FMT20   = 8'h20;
  localparam logic [7:0]  FN_OFF     = 8'hff;
  localparam logic [1:0]  SUPP_BAD   = 2'h3;
  localparam logic [15:0] UL_OFF     = 16'h7fff;
  localparam logic [15:0] LL_OFF     = 16'h8000;
  localparam logic signed [15:0] NOM10 = 16'sh6c00;
  localparam logic signed [15:0] NOM20 = 16'sh4000;
  localparam logic signed [15:0] OVR10 = 16'sh7eff;
  localparam logic signed [15:0] UDR10 = 16'shed00;
  localparam logic signed [15:0] OVR20 = 16'sh5000;
  localparam logic signed [15:0] UDR20 = 16'shf333;
  // 16384/27648 as a 16-bit fraction, rounded up so 6c00h lands on 4000h.
  localparam logic [16:0] SCALE20    = 17'h097b5;
  localparam logic [3:0]  CH_ONE     = 4'h1;
  // ==========================================================
  // Timing
  localparam int          CLK_NS     = 20;
  localparam int          TICK_NS    = 1000;
  localparam logic [5:0]  TICK_CYC   = 6'(TICK_NS / CLK_NS);
  // ==========================================================
  // Diagnostic cause bits
  localparam int DC_PRM = 0;
  localparam int DC_OVF = 1;
  localparam int DC_UDF = 2;
  localparam int DC_BUF = 3;
  localparam int DC_COM = 4;
  localparam int DC_LST = 5;
  localparam int DC_W   = 6;
  typedef enum logic [1:0] {DG_IDLE = 2'b01, DG_ACTIVE = 2'b10} aim_diag_st_t;
endpackage

//--- hdl/aim_limit_monitor.sv
// Purpose: Parameter store, scaling, limit monitoring and events of a
//          four-channel 0 to 10 V analog input.
// Assumes: Samples arrive already converted, in 10h units, one per cycle.
// Notes:   Records are read byte-wise by subindex; the coupler forwards them.
`timescale 1ns/1ps

// Summary of operation
// - Diag byte 00h disables, 40h enables
// - Limit enable bits 0..3, one per channel
// - Suppression byte: two bits per channel
// - Selector 00 off, 01 60Hz, 10 50Hz
// - Function FFh switches a channel off
// - Format 10h: 10 V gives 6C00h
// - Format 20h: 10 V gives 4000h
// - Overrange and underrange codes clamp per format
// - Limits outside nominal range flag parameter error unless the channel is off
// - 7FFFh upper, 8000h lower disable checking
// - Enabled channel outside band raises hardware interrupt
// - Fault causes raise diagnostic interrupt, limits hardware
// - Record overflow byte, bit per channel
// - Record underflow byte, bit per channel
// - Timestamp high at 04h, low at 05h
// - Free 32-bit microsecond counter, wraps to zero
// - Timestamp is counter low sixteen bits
// - Record is delivered through the coupler
// - Cause gone gives outgoing event; middle events lost
module aim_limit_monitor
  import aim_pkg::*;
(
  input  wire logic               clk_sys_i,
  input  wire logic               rstn_i,
  input  wire logic               prm_wr_i,
  input  wire logic [7:0]         prm_idx_i,
  input  wire logic [15:0]        prm_wdata_i,
  input  wire logic               rec_rd_i,
  input  wire logic [7:0]         rec_idx_i,
  output logic      [7:0]         rec_rdata_o,
  output logic                    rec_valid_o,
  input  wire logic               smp_valid_i,
  input  wire logic [1:0]         smp_ch_i,
  input  wire logic signed [15:0] smp_raw_i,
  output logic                    meas_valid_o,
  output logic      [1:0]         meas_ch_o,
  output logic signed [15:0]      meas_data_o,
  output logic      [7:0]         supp_sel_o,
  output logic      [NCH-1:0]     chan_on_o,
  output logic                    hw_irq_o,
  input  wire logic               hw_ack_i,
  input  wire logic               diag_buf_ovf_i,
  input  wire logic               diag_comm_err_i,
  output logic                    diag_in_o,
  output logic                    diag_out_o,
  output logic      [DC_W-1:0]    diag_cause_o,
  output logic                    prm_err_o
);

  function automatic logic in_nominal(logic signed [15:0] v, logic [7:0] fn);
    in_nominal = (v >= 0) && (v <= ((fn == FN_FMT20) ? NOM20 : NOM10));
  endfunction

  // ==========================================================
  // Parameter registers
  logic [7:0]         dgi_en_q;
  logic [NCH-1:0]     lim_en_q;
  logic [7:0]         supp_q;
  logic [7:0]         fn_q [NCH];
  logic signed [15:0] ul_q [NCH];
  logic signed [15:0] ll_q [NCH];
  logic [7:0]         ch_off_w;
  logic               ch_hit_w;
  logic [1:0]         wch_w;
  logic [1:0]         wslot_w;

  assign ch_off_w = prm_idx_i - SX_CH_BASE;
  assign ch_hit_w = prm_wr_i && (prm_idx_i >= SX_CH_BASE) && (ch_off_w < SX_CH_SPAN);
  assign wch_w    = ch_off_w[3:2];
  assign wslot_w  = ch_off_w[1:0];

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dgi_en_q  <= DIAG_OFF;
      lim_en_q  <= '0;
      supp_q    <= '0;
    end
    else if (prm_wr_i)
    begin
      if (prm_idx_i == SX_DGI_EN)  dgi_en_q  <= prm_wdata_i[7:0];
      if (prm_idx_i == SX_LIM_EN)  lim_en_q  <= prm_wdata_i[NCH-1:0];
      if (prm_idx_i == SX_SUPP)    supp_q    <= prm_wdata_i[7:0];
    end
  end

  // ==========================================================
  // Per-channel state
  logic [NCH-1:0] bad_w;
  logic [NCH-1:0] rng_ovf_q;
  logic [NCH-1:0] rng_udf_q;
  logic           rng_hi_w;
  logic           rng_lo_w;
  logic           do_smp_w;

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic sel_w;
    assign sel_w = ch_hit_w && (wch_w == 2'(c));

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
      if (!rstn_i)
      begin
        fn_q[c] <= FN_FMT10;
        ul_q[c] <= UL_OFF;
        ll_q[c] <= LL_OFF;
      end
      else if (sel_w)
      begin
        if (wslot_w == SLOT_FN) fn_q[c] <= prm_wdata_i[7:0];
        if (wslot_w == SLOT_UL) ul_q[c] <= prm_wdata_i;
        if (wslot_w == SLOT_LL) ll_q[c] <= prm_wdata_i;
      end
    end

    // A switched-off channel is exempt from limit checks.
    assign bad_w[c] = ((fn_q[c] != FN_FMT10) && (fn_q[c] != FN_FMT20)
                       && (fn_q[c] != FN_OFF))
                    || (supp_q[2*c +: 2] == SUPP_BAD)
                    || ((fn_q[c] != FN_OFF) && (ul_q[c] != UL_OFF)
                        && !in_nominal(ul_q[c], fn_q[c]))
                    || ((fn_q[c] != FN_OFF) && (ll_q[c] != LL_OFF)
                        && !in_nominal(ll_q[c], fn_q[c]));

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
      if (!rstn_i)
      begin
        rng_ovf_q[c] <= 1'b0;
        rng_udf_q[c] <= 1'b0;
        chan_on_o[c] <= 1'b0;
      end
      else
      begin
        chan_on_o[c] <= (fn_q[c] != FN_OFF);
        if (fn_q[c] == FN_OFF)
        begin
          rng_ovf_q[c] <= 1'b0;
          rng_udf_q[c] <= 1'b0;
        end
        else if (do_smp_w && (smp_ch_i == 2'(c)))
        begin
          rng_ovf_q[c] <= rng_hi_w;
          rng_udf_q[c] <= rng_lo_w;
        end
      end
    end
  end

  // ==========================================================
  // Scaling
  logic [7:0]         fn_s_w;
  logic signed [15:0] c10_w;
  logic signed [32:0] prod_w;
  logic signed [15:0] s20_w;
  logic signed [15:0] c20_w;
  logic signed [15:0] val_w;

  assign fn_s_w   = fn_q[smp_ch_i];
  assign do_smp_w = smp_valid_i && (fn_s_w != FN_OFF);
  assign rng_hi_w = smp_raw_i > OVR10;
  assign rng_lo_w = smp_raw_i < UDR10;
  assign c10_w    = rng_hi_w ? OVR10 : (rng_lo_w ? UDR10 : smp_raw_i);
  assign prod_w   = c10_w * $signed({1'b0, SCALE20});
  assign s20_w    = prod_w[VAL_W +: VAL_W];
  assign c20_w    = (s20_w > OVR20) ? OVR20 : ((s20_w < UDR20) ? UDR20 : s20_w);
  assign val_w    = (fn_s_w == FN_FMT20) ? c20_w : c10_w;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meas_valid_o <= 1'b0;
      meas_ch_o    <= '0;
      meas_data_o  <= '0;
    end
    else
    begin
      meas_valid_o <= do_smp_w;
      if (do_smp_w)
      begin
        meas_ch_o   <= smp_ch_i;
        meas_data_o <= val_w;
      end
    end
  end

  // ==========================================================
  // Microsecond ticker
  logic [5:0]  pre_q;
  logic [31:0] us_q;
  logic        tick_w;

  assign tick_w = (pre_q == TICK_CYC - 6'h01);

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pre_q <= '0;
      us_q  <= '0;
    end
    else
    begin
      pre_q <= tick_w ? '0 : pre_q + 6'h01;
      if (tick_w) us_q <= us_q + 32'h1;
    end
  end

  // ==========================================================
  // Limit checks and hardware-interrupt record
  logic           mon_w;
  logic           ovf_hit_w;
  logic           udf_hit_w;
  logic [NCH-1:0] evt_ovf_w;
  logic [NCH-1:0] evt_udf_w;
  logic           hw_evt_w;
  logic           hw_cap_w;
  logic           hw_lost_w;
  logic [NCH-1:0] rec_ovf_q;
  logic [NCH-1:0] rec_udf_q;
  logic [15:0]    rec_ts_q;
  logic           lost_q;

  assign mon_w     = do_smp_w && lim_en_q[smp_ch_i];
  assign ovf_hit_w = mon_w && (ul_q[smp_ch_i] != UL_OFF)
                     && (val_w > ul_q[smp_ch_i]);
  assign udf_hit_w = mon_w && (ll_q[smp_ch_i] != LL_OFF)
                     && (val_w < ll_q[smp_ch_i]);
  assign evt_ovf_w = ovf_hit_w ? (CH_ONE << smp_ch_i) : '0;
  assign evt_udf_w = udf_hit_w ? (CH_ONE << smp_ch_i) : '0;
  assign hw_evt_w  = ovf_hit_w || udf_hit_w;
  // An event in the acknowledge cycle still opens a fresh record.
  assign hw_cap_w  = hw_evt_w && (!hw_irq_o || hw_ack_i);
  assign hw_lost_w = hw_evt_w && hw_irq_o && !hw_ack_i;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hw_irq_o  <= 1'b0;
      rec_ovf_q <= '0;
      rec_udf_q <= '0;
      rec_ts_q  <= '0;
      lost_q    <= 1'b0;
    end
    else
    begin
      if (hw_cap_w)
      begin
        hw_irq_o  <= 1'b1;
        rec_ovf_q <= evt_ovf_w;
        rec_udf_q <= evt_udf_w;
        rec_ts_q  <= us_q[15:0];
      end
      else if (hw_ack_i)
        hw_irq_o <= 1'b0;
      if (hw_lost_w)
        lost_q <= 1'b1;
      else if (hw_ack_i)
        lost_q <= 1'b0;
    end
  end

  // ==========================================================
  // Record read port
  logic [7:0] rec_rd_w;

  assign rec_rd_w = (rec_idx_i == SX_REC_OVF) ? {4'h0, rec_ovf_q}
                  : (rec_idx_i == SX_REC_UDF) ? {4'h0, rec_udf_q}
                  : (rec_idx_i == SX_REC_TSH) ? rec_ts_q[15:8]
                  : (rec_idx_i == SX_REC_TSL) ? rec_ts_q[7:0]
                  : 8'h00;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rec_valid_o <= 1'b0;
      rec_rdata_o <= '0;
    end
    else
    begin
      rec_valid_o <= rec_rd_i;
      if (rec_rd_i) rec_rdata_o <= rec_rd_w;
    end
  end

  // ==========================================================
  // Diagnostic interrupt
  aim_diag_st_t    st_q;
  logic [DC_W-1:0] cause_w;
  logic            dg_en_w;

  assign dg_en_w = (dgi_en_q == DIAG_ON);
  assign cause_w[DC_PRM] = prm_err_o;
  assign cause_w[DC_OVF] = |rng_ovf_q;
  assign cause_w[DC_UDF] = |rng_udf_q;
  assign cause_w[DC_BUF] = diag_buf_ovf_i;
  assign cause_w[DC_COM] = diag_comm_err_i;
  assign cause_w[DC_LST] = lost_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prm_err_o    <= 1'b0;
      supp_sel_o   <= '0;
      st_q         <= DG_IDLE;
      diag_in_o    <= 1'b0;
      diag_out_o   <= 1'b0;
      diag_cause_o <= '0;
    end
    else
    begin
      prm_err_o  <= (|bad_w) || ((dgi_en_q != DIAG_OFF) && !dg_en_w);
      supp_sel_o <= supp_q;
      diag_in_o  <= 1'b0;
      diag_out_o <= 1'b0;
      case (st_q)
        DG_IDLE:
        begin
          if (dg_en_w && (|cause_w))
          begin
            st_q         <= DG_ACTIVE;
            diag_in_o    <= 1'b1;
            diag_cause_o <= cause_w;
          end
        end
        DG_ACTIVE:
        begin
          // Causes seen while active are not stored; only the exit is reported.
          if (!(|cause_w) || !dg_en_w)
          begin
            st_q       <= DG_IDLE;
            diag_out_o <= 1'b1;
          end
        end
        default: st_q <= DG_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence s_gone;
    (st_q == DG_ACTIVE) && !(|cause_w) ##1 1'b1;
  endsequence

  a_diag_gate_code: assert property (diag_in_o |-> $past(dgi_en_q) == DIAG_ON)
    else $error("diag event while disabled");
  a_limit_en_gate: assert property ($rose(hw_irq_o) |->
      ((rec_ovf_q | rec_udf_q) & ~$past(lim_en_q)) == '0)
    else $error("record bit on unmonitored channel");
  a_supp_write_out: assert property (prm_wr_i && (prm_idx_i == SX_SUPP) |->
      ##2 supp_sel_o == $past(prm_wdata_i[7:0], 2))
    else $error("suppression byte not applied");
  a_supp_bad_code: assert property (((supp_q[1:0] == SUPP_BAD) || (supp_q[7:6] == SUPP_BAD))
      |=> prm_err_o)
    else $error("bad suppression code not flagged");
  a_chan_off_quiet: assert property (smp_valid_i && (fn_s_w == FN_OFF) |=> !meas_valid_o)
    else $error("sample taken on switched-off channel");
  a_fmt10_full: assert property (smp_valid_i && (fn_s_w == FN_FMT10) && (smp_raw_i == NOM10)
      |=> meas_data_o == NOM10)
    else $error("format 10h full scale wrong");
  a_fmt20_full: assert property (smp_valid_i && (fn_s_w == FN_FMT20) && (smp_raw_i == NOM10)
      |=> meas_data_o == NOM20)
    else $error("format 20h full scale wrong");
  a_fmt20_span: assert property (smp_valid_i && (fn_s_w == FN_FMT20)
      |=> (meas_data_o <= OVR20) && (meas_data_o >= UDR20))
    else $error("format 20h code out of span");
  a_limit_bad_err: assert property (ch_hit_w && (wslot_w == SLOT_UL)
      && (prm_wdata_i != UL_OFF) && (fn_q[wch_w] != FN_OFF)
      && !in_nominal(prm_wdata_i, fn_q[wch_w]) |-> ##2 prm_err_o)
    else $error("out-of-range limit not flagged");
  a_upper_off: assert property (mon_w && (ul_q[smp_ch_i] == UL_OFF) && !udf_hit_w
      |-> !hw_cap_w)
    else $error("disabled upper limit fired");
  a_over_raises: assert property (mon_w && (val_w > ul_q[smp_ch_i]) && (ul_q[smp_ch_i] != UL_OFF)
      && !hw_irq_o |=> hw_irq_o && rec_ovf_q[$past(smp_ch_i)])
    else $error("limit overflow did not interrupt");
  a_stamp_low: assert property (hw_cap_w |=> rec_ts_q == $past(us_q[15:0]))
    else $error("timestamp not counter low half");
  a_stamp_high: assert property (rec_rd_i && (rec_idx_i == SX_REC_TSH)
      |=> rec_valid_o && rec_rdata_o == $past(rec_ts_q[15:8]))
    else $error("timestamp high byte wrong");
  a_tick_step: assert property (tick_w |=> us_q == $past(us_q) + 32'h1)
    else $error("ticker did not step");
  a_diag_going: assert property (s_gone |-> diag_out_o && (st_q == DG_IDLE))
    else $error("no outgoing diag event");

endmodule // aim_limit_monitor

//--- tb/aim_coupler_model.sv
// Purpose: Bus coupler model that fetches every hardware-interrupt record.
// Assumes: A record byte answers one cycle after its read strobe.
// Notes:   Reads both timestamp bytes before it acknowledges the record.
`timescale 1ns/1ps
module aim_coupler_model
  import aim_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        hw_irq_i,
  input  wire logic        rec_valid_i,
  input  wire logic [7:0]  rec_rdata_i,
  output logic             rec_rd_o,
  output logic      [7:0]  rec_idx_o,
  output logic             hw_ack_o,
  output logic      [7:0]  ovf_o,
  output logic      [7:0]  udf_o,
  output logic      [15:0] ts_o,
  output logic      [7:0]  cnt_o
);
  logic [7:0] byte_q;

  // A missing answer leaves an unknown byte so the bench sees it.
  task automatic fetch(input logic [7:0] idx);
    rec_rd_o  = 1'b1;
    rec_idx_o = idx;
    @(negedge clk_sys_i);
    byte_q    = rec_valid_i ? rec_rdata_i : 8'hxx;
  endtask

  initial
  begin
    rec_rd_o  = 1'b0;
    rec_idx_o = 8'h00;
    hw_ack_o  = 1'b0;
    cnt_o     = 8'h00;
    forever
    begin
      @(negedge clk_sys_i);
      if (hw_irq_i === 1'b1)
      begin
        fetch(SX_REC_OVF);
        ovf_o = byte_q;
        fetch(SX_REC_UDF);
        udf_o = byte_q;
        fetch(SX_REC_TSH);
        ts_o[15:8] = byte_q;
        fetch(SX_REC_TSL);
        ts_o[7:0] = byte_q;
        rec_rd_o  = 1'b0;
        rec_idx_o = 8'hff;
        hw_ack_o  = 1'b1;
        @(negedge clk_sys_i);
        hw_ack_o = 1'b0;
        cnt_o <= cnt_o + 8'h01;
        @(negedge clk_sys_i);
      end
    end
  end
endmodule // aim_coupler_model

//--- tb/testbench.sv
// Purpose: Self-checking bench for the analog input limit monitor.
// Assumes: Inputs change on the falling clock edge only.
// Notes:   The coupler model acknowledges each record after reading its four bytes.
`timescale 1ns/1ps
module testbench;
  import aim_pkg::*;
  logic               clk_sys_i = 1'b0;
  logic               rstn_i = 1'b0;
  logic               prm_wr_i = 1'b0;
  logic [7:0]         prm_idx_i = 8'h00;
  logic [15:0]        prm_wdata_i = 16'h0000;
  logic               smp_valid_i = 1'b0;
  logic [1:0]         smp_ch_i = 2'h0;
  logic signed [15:0] smp_raw_i = 16'sh0000;
  logic               diag_buf_ovf_i = 1'b0;
  logic               diag_comm_err_i = 1'b0;
  logic               rec_rd_i, rec_valid_o, hw_ack_i, meas_valid_o, hw_irq_o;
  logic               diag_in_o, diag_out_o, prm_err_o;
  logic [7:0]         rec_idx_i, rec_rdata_o, supp_sel_o, ovf, udf, cnt;
  logic [1:0]         meas_ch_o;
  logic signed [15:0] meas_data_o;
  logic [3:0]         chan_on_o;
  logic [5:0]         diag_cause_o;
  logic [15:0]        ts;
  int                 fail_count = 0;
  int                 num_checks = 0;
  int                 cyc, smp_cyc;

  always #10 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i) cyc <= 0;
    else cyc <= cyc + 1;

  aim_limit_monitor i_dut (.clk_sys_i, .rstn_i, .prm_wr_i, .prm_idx_i, .prm_wdata_i,
    .rec_rd_i, .rec_idx_i, .rec_rdata_o, .rec_valid_o, .smp_valid_i, .smp_ch_i,
    .smp_raw_i, .meas_valid_o, .meas_ch_o, .meas_data_o, .supp_sel_o, .chan_on_o,
    .hw_irq_o, .hw_ack_i, .diag_buf_ovf_i, .diag_comm_err_i, .diag_in_o,
    .diag_out_o, .diag_cause_o, .prm_err_o);

  aim_coupler_model i_cpl (.clk_sys_i, .hw_irq_i(hw_irq_o), .rec_valid_i(rec_valid_o),
    .rec_rdata_i(rec_rdata_o), .rec_rd_o(rec_rd_i), .rec_idx_o(rec_idx_i),
    .hw_ack_o(hw_ack_i), .ovf_o(ovf), .udf_o(udf), .ts_o(ts), .cnt_o(cnt));

  // ==========================================================
  // Access tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Waits two edges so the error flag and suppression output have settled.
  task automatic prm(input logic [7:0] idx, input logic [15:0] d);
    prm_wr_i    = 1'b1;
    prm_idx_i   = idx;
    prm_wdata_i = d;
    @(negedge clk_sys_i);
    prm_wr_i = 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic smp(input logic [1:0] ch, input logic [15:0] raw, input logic v,
                     input logic [15:0] d);
    smp_valid_i = 1'b1;
    smp_ch_i    = ch;
    smp_raw_i   = raw;
    @(negedge clk_sys_i);
    smp_valid_i = 1'b0;
    smp_cyc     = cyc;
    check({15'h0, meas_valid_o}, {15'h0, v});
    if (v)
    begin
      check(meas_data_o, d);
      check({14'h0, meas_ch_o}, {14'h0, ch});
    end
  endtask

  // The timestamp counts microseconds, so it may lag the cycle count by one tick.
  task automatic rec(input logic irq, input logic [7:0] o, input logic [7:0] u);
    logic [7:0] c0;
    c0 = cnt;
    check({15'h0, hw_irq_o}, {15'h0, irq});
    if (irq)
    begin
      repeat (20) if (cnt == c0) @(negedge clk_sys_i);
      check({8'h0, ovf}, {8'h0, o});
      check({8'h0, udf}, {8'h0, u});
      check({15'h0, (int'(ts) * 50 <= smp_cyc) && (smp_cyc < int'(ts) * 50 + 100)}, 16'h1);
    end
  endtask

  task automatic cause(input logic en);
    diag_buf_ovf_i = 1'b1;
    @(negedge clk_sys_i);
    check({15'h0, diag_in_o}, {15'h0, en});
    if (en)
      check({10'h0, diag_cause_o}, 16'h0008);
    diag_buf_ovf_i = 1'b0;
    @(negedge clk_sys_i);
    check({15'h0, diag_out_o}, {15'h0, en});
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    @(negedge clk_sys_i);
    check({8'h0, supp_sel_o}, 16'h0000);
    check({12'h0, chan_on_o}, 16'h000f);
    check({15'h0, prm_err_o}, 16'h0000);
    prm(SX_SUPP, 16'h0024);
    check({8'h0, supp_sel_o}, 16'h0024);
    prm(SX_SUPP, 16'h00c0);
    check({15'h0, prm_err_o}, 16'h0001);
    prm(SX_SUPP, 16'h0098);
    check({8'h0, supp_sel_o}, 16'h0098);
    check({15'h0, prm_err_o}, 16'h0000);
    // Enables are written here as if the controller were stopped.
    prm(SX_DGI_EN, 16'h0041);
    check({15'h0, prm_err_o}, 16'h0001);
    prm(SX_DGI_EN, 16'h0000);
    check({15'h0, prm_err_o}, 16'h0000);
    cause(1'b0);
    prm(SX_DGI_EN, 16'h0040);
    cause(1'b1);
    prm(SX_DGI_EN, 16'h0000);
    prm(SX_CH_BASE + 8'h08, 16'h0020);
    smp(2'h0, 16'h6c00, 1'b1, 16'h6c00);
    smp(2'h0, 16'h7fff, 1'b1, 16'h7eff);
    smp(2'h0, 16'h8000, 1'b1, 16'hed00);
    smp(2'h2, 16'h6c00, 1'b1, 16'h4000);
    smp(2'h2, 16'h3600, 1'b1, 16'h2000);
    smp(2'h2, 16'h0000, 1'b1, 16'h0000);
    prm(SX_CH_BASE + 8'h04, 16'h00ff);
    check({12'h0, chan_on_o}, 16'h000d);
    smp(2'h1, 16'h1000, 1'b0, 16'h0000);
    prm(SX_CH_BASE + 8'h02, 16'h7000);
    check({15'h0, prm_err_o}, 16'h0001);
    prm(SX_CH_BASE + 8'h02, 16'h3000);
    check({15'h0, prm_err_o}, 16'h0000);
    prm(SX_LIM_EN, 16'h0009);
    smp(2'h0, 16'h3000, 1'b1, 16'h3000);
    rec(1'b0, 8'h00, 8'h00);
    smp(2'h0, 16'h3001, 1'b1, 16'h3001);
    rec(1'b1, 8'h01, 8'h00);
    prm(SX_CH_BASE + 8'h0f, 16'h1000);
    smp(2'h3, 16'h0fff, 1'b1, 16'h0fff);
    rec(1'b1, 8'h00, 8'h08);
    prm(SX_CH_BASE + 8'h0f, 16'h8000);
    smp(2'h3, 16'h0000, 1'b1, 16'h0000);
    rec(1'b0, 8'h00, 8'h00);
    prm(SX_LIM_EN, 16'h0008);
    smp(2'h0, 16'h7000, 1'b1, 16'h7000);
    rec(1'b0, 8'h00, 8'h00);
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    results();
  end
endmodule // testbench
